// [src/sabc_top.sv]
// control logic of an 8-bit successive approximation converter on a host bus
// How it works
// R1: once the marker leaves the last stage, the result moves into output latches
// R2: internal phases run at one eighth of mclk; done set pulse lasts eight clocks
// R3: done flip-flop set drives the active-low interrupt output low
// R4: with select and read held low, interrupt still pulses low for eight clocks
// R5: in free-running mode the interrupt falling edge restarts conversion and clears it
// R6: free-running interrupt low pulse is about 300 ns wide
// R7: select and read low clear the done flip-flop and enable the data outputs
// R8: select, read and write are active-low bus controls
// R9: standalone host may tie select low and pulse write and read
// R10: positive and negative inputs are sampled four clocks apart
// R11: eight comparisons, msb first, 64 clocks; all ones is full scale
// R12: select and write low hold reset; conversion starts 1 to 8 clocks after release
// R13: output latch updates one clock before the interrupt asserts
// R14: host reads no earlier than eight clocks after interrupt asserts
// R15: data outputs release when read or select goes high
// R16: a new start aborts conversion and restarts from the msb
`timescale 1ns/10ps
module sabc_top (
    // clock and reset
    input  wire logic                 mclk_i,
    input  wire logic                 srst_i,
    // host bus pins
    input  wire logic                 cs_n_i,
    input  wire logic                 rd_n_i,
    input  wire logic                 wr_n_i,
    output logic [7:0]                data_o,
    output logic [7:0]                data_oe_o,
    output logic                      conv_done_irq_n_o,
    // analog side
    input  wire logic                 comp_i,
    output logic [7:0]                ladder_code_o,
    output logic                      sample_pos_o,
    output logic                      sample_neg_o
);
    sabc_pkg::sabc_bus_t bus;
    sabc_pkg::sabc_state_t state_q;
    logic       comp_s;
    logic [2:0] phase_q;
    logic       phase_en;
    logic [7:0] approx_register_q;
    logic [7:0] shift_q;
    logic [7:0] latch_q;
    logic       xfer_q;
    logic [3:0] set_cnt_q;
    logic [7:0] free_cnt_q;
    logic       irq_ff_q;
    logic       irq_pin_q;
    logic       wr_prev_q;
    logic       start_req;
    logic       start_hold;
    logic       read_en;
    logic       start_clear_gate;
    logic       result_transfer_gate;

    sabc_sync u_cs (.mclk_i(mclk_i), .srst_i(srst_i), .pin_i(cs_n_i),
                    .rst_val_i(1'b1), .sync_o(bus.cs_n));
    sabc_sync u_rd (.mclk_i(mclk_i), .srst_i(srst_i), .pin_i(rd_n_i),
                    .rst_val_i(1'b1), .sync_o(bus.rd_n));
    sabc_sync u_wr (.mclk_i(mclk_i), .srst_i(srst_i), .pin_i(wr_n_i),
                    .rst_val_i(1'b1), .sync_o(bus.wr_n));
    sabc_sync u_cp (.mclk_i(mclk_i), .srst_i(srst_i), .pin_i(comp_i),
                    .rst_val_i(1'b1), .sync_o(comp_s));

    // selects are active low throughout
    assign start_hold = !bus.cs_n && !bus.wr_n; // R8 R12
    assign start_req  = start_hold && wr_prev_q; // R5 R16
    assign read_en    = !bus.cs_n && !bus.rd_n; // R7 R8
    assign phase_en   = (phase_q == sabc_pkg::PHASE_LAST); // R2
    assign start_clear_gate     = phase_en && (state_q == sabc_pkg::SABC_HOLD) && !start_hold;
    assign result_transfer_gate = phase_en && (state_q == sabc_pkg::SABC_CONV) && shift_q[0];

    // phase divider free runs, so start lands 1 to 8 clocks after release
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            phase_q <= 3'h0;
        end else begin
            phase_q <= phase_q + 3'h1; // R2 R12
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            wr_prev_q <= 1'b0;
        end else begin
            wr_prev_q <= !start_hold;
        end
    end

    // start flip-flop and search sequencing
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            state_q <= sabc_pkg::SABC_IDLE;
        end else if (start_hold) begin
            state_q <= sabc_pkg::SABC_HOLD; // R12 R16
        end else begin
            unique case (state_q)
                sabc_pkg::SABC_IDLE: begin
                    state_q <= sabc_pkg::SABC_IDLE;
                end
                sabc_pkg::SABC_HOLD: begin
                    if (start_clear_gate) begin
                        state_q <= sabc_pkg::SABC_CONV;
                    end
                end
                sabc_pkg::SABC_CONV: begin
                    if (result_transfer_gate) begin
                        state_q <= sabc_pkg::SABC_IDLE;
                    end
                end
                default: begin
                    state_q <= sabc_pkg::SABC_IDLE;
                end
            endcase
        end
    end

    // marker shift register and approximation register, msb first
    always_ff @(posedge mclk_i) begin
        if (srst_i || start_hold) begin
            shift_q           <= sabc_pkg::DATA_RESET; // R5 R16
            approx_register_q <= sabc_pkg::DATA_RESET;
        end else if (start_clear_gate) begin
            shift_q           <= sabc_pkg::MSB_MARK; // R11
            approx_register_q <= sabc_pkg::MSB_MARK;
        end else if (phase_en && state_q == sabc_pkg::SABC_CONV) begin
            shift_q <= shift_q >> 1; // R11
            // comparator high means ladder above input, so drop the trial bit
            approx_register_q <= (approx_register_q & ~(shift_q & {8{comp_s}}))
                                 | (shift_q >> 1);
        end
    end

    // sampling strobes half a phase apart for the differential pair
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            sample_pos_o <= 1'b0;
            sample_neg_o <= 1'b0;
        end else begin
            sample_pos_o <= (state_q == sabc_pkg::SABC_CONV) && (phase_q == 3'h0); // R10
            sample_neg_o <= (state_q == sabc_pkg::SABC_CONV)
                            && (phase_q == sabc_pkg::NEG_SAMPLE_PH); // R10
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            ladder_code_o <= sabc_pkg::DATA_RESET;
        end else begin
            ladder_code_o <= approx_register_q;
        end
    end

    // result latch; final bit resolved in the same cycle as the transfer
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            latch_q <= sabc_pkg::DATA_RESET;
            xfer_q  <= 1'b0;
        end else begin
            xfer_q <= result_transfer_gate; // R13
            if (result_transfer_gate) begin
                latch_q <= approx_register_q & ~(shift_q & {8{comp_s}}); // R1 R11
            end
        end
    end

    // done flip-flop: set pulse of eight clocks beats the read clear
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            set_cnt_q <= 4'h0;
        end else if (start_hold) begin
            set_cnt_q <= 4'h0; // R4
        end else if (xfer_q) begin
            set_cnt_q <= sabc_pkg::SET_PULSE_CYC; // R2 R13
        end else if (set_cnt_q != 4'h0) begin
            set_cnt_q <= set_cnt_q - 4'h1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            irq_ff_q <= 1'b0;
        end else if (xfer_q || (set_cnt_q > 4'h1)) begin
            irq_ff_q <= 1'b1; // R3 R4
        end else if (read_en || start_hold) begin
            irq_ff_q <= 1'b0; // R7 R5
        end
    end

    // free-running: a low pin pulse restarts, keep it visible about 300 ns
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            free_cnt_q <= 8'h00;
        end else if (start_req && irq_ff_q) begin
            // only a start landing on a pending interrupt stretches the pin
            free_cnt_q <= sabc_pkg::FREE_PULSE_W; // R6
        end else if (free_cnt_q != 8'h00) begin
            free_cnt_q <= free_cnt_q - 8'h01;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            irq_pin_q <= 1'b1;
        end else begin
            // a held start masks the flip-flop from the pin, so the counter alone holds the pin
            irq_pin_q <= !((irq_ff_q && (!start_hold || start_req))
                           || (free_cnt_q != 8'h00)); // R3 R6
        end
    end
    assign conv_done_irq_n_o = irq_pin_q;

    // output drivers
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            data_o    <= sabc_pkg::DATA_RESET;
            data_oe_o <= 8'h00;
        end else begin
            data_o    <= latch_q;
            data_oe_o <= {8{read_en}}; // R7 R15
        end
    end
endmodule

// [src/sabc_pkg.sv]
// shared constants and types for the converter bus control block
package sabc_pkg;
    localparam int unsigned DATA_W        = 8;
    localparam int unsigned PHASE_DIV     = 8;
    localparam logic [2:0]  PHASE_LAST    = 3'h7;
    localparam logic [3:0]  SET_PULSE_CYC = 4'h8;
    localparam logic [2:0]  NEG_SAMPLE_PH = 3'h4;
    localparam int unsigned MCLK_MHZ      = 200;
    localparam int unsigned FREE_PULSE_NS = 300;
    localparam int unsigned FREE_PULSE_CYC = (FREE_PULSE_NS * MCLK_MHZ) / 1000;
    localparam logic [7:0]  FREE_PULSE_W  = 8'(FREE_PULSE_CYC);
    localparam logic [7:0]  MSB_MARK      = 8'h80;
    localparam logic [7:0]  DATA_RESET    = 8'h00;

    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic wr_n;
    } sabc_bus_t;

    typedef enum logic [2:0] {
        SABC_IDLE  = 3'b001,
        SABC_HOLD  = 3'b010,
        SABC_CONV  = 3'b100
    } sabc_state_t;
endpackage

// [src/sabc_sync.sv]
// two flip-flop synchroniser for one pin
`timescale 1ns/10ps
module sabc_sync (
    // clock and reset
    input  wire logic mclk_i,
    input  wire logic srst_i,
    // pin and synced level
    input  wire logic pin_i,
    input  wire logic rst_val_i,
    output logic      sync_o
);
    logic meta_q;
    logic sync_q;

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            // reset to the pin's idle level so no false edge follows reset
            meta_q <= rst_val_i;
            sync_q <= rst_val_i;
        end else begin
            meta_q <= pin_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;
endmodule

// [verification/sabc_comp_model.sv]
// comparator stand-in for the analog side of the converter
`timescale 1ns/10ps
module sabc_comp_model (
    // analog input level and ladder tap
    input  wire logic [7:0] vin_i,
    input  wire logic [7:0] ladder_i,
    // comparator decision
    output logic            comp_o
);
    // ideal comparator: ladder above input drops the trial bit, so the code settles at vin
    assign comp_o = (ladder_i > vin_i);
endmodule

// [verification/sabc_monitor.sv]
// assertion checker on the converter control ports
`timescale 1ns/10ps
module sabc_monitor (
    // clock and reset
    input wire logic       mclk_i,
    input wire logic       srst_i,
    // host bus
    input wire logic       cs_n_i,
    input wire logic       rd_n_i,
    input wire logic       wr_n_i,
    input wire logic [7:0] data_o,
    input wire logic [7:0] data_oe_o,
    input wire logic       conv_done_irq_n_o,
    // analog strobes
    input wire logic       sample_pos_o,
    input wire logic       sample_neg_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);
    a_oe_on_read: assert property ((!cs_n_i && !rd_n_i)[*6] |-> data_oe_o == 8'hff)
        else $error("outputs not enabled by read");
    a_oe_all_bits: assert property (data_oe_o == 8'h00 || data_oe_o == 8'hff)
        else $error("output enable split");
    a_oe_release: assert property ((cs_n_i || rd_n_i)[*6] |-> data_oe_o == 8'h00)
        else $error("outputs not released");
    a_irq_min_low: assert property ($fell(conv_done_irq_n_o) |->
        (!conv_done_irq_n_o)[*8] or (##[0:7] !wr_n_i))
        else $error("interrupt pulse too short");
    a_data_before_irq: assert property ($changed(data_o) |-> ##[1:2] $fell(conv_done_irq_n_o))
        else $error("result not followed by interrupt");
    a_start_holds: assert property ((!cs_n_i && !wr_n_i)[*4] |=> !sample_pos_o && !sample_neg_o)
        else $error("sampling while held in start");
    a_pos_single: assert property (sample_pos_o |=> !sample_pos_o)
        else $error("positive strobe too long");
    a_neg_after_pos: assert property ((sample_pos_o && $past(wr_n_i) && wr_n_i)
        ##1 (cs_n_i || wr_n_i)[*3] |=> sample_neg_o)
        else $error("negative strobe not four clocks later");
endmodule

bind sabc_top sabc_monitor u_mon (.mclk_i, .srst_i, .cs_n_i, .rd_n_i, .wr_n_i, .data_o,
    .data_oe_o, .conv_done_irq_n_o, .sample_pos_o, .sample_neg_o);

// [verification/testbench.sv]
// self-checking bench for the converter bus control block
`timescale 1ns/10ps
module testbench;
    logic       mclk_i;
    logic       srst_i;
    logic       cs_n_i;
    logic       rd_n_i;
    logic       wr_n_i;
    logic       comp_i;
    logic       free_q;
    logic [7:0] vin;
    logic [7:0] data_o;
    logic [7:0] data_oe_o;
    logic [7:0] ladder_code_o;
    logic       conv_done_irq_n_o;
    logic [7:0] codes [4] = '{8'hff, 8'h00, 8'ha5, 8'h5a};
    int         n_fail;
    int         check_count;
    int         n;
    sabc_top DUT (.mclk_i, .srst_i, .cs_n_i, .rd_n_i, .wr_n_i, .data_o, .data_oe_o,
        .conv_done_irq_n_o, .comp_i, .ladder_code_o, .sample_pos_o(), .sample_neg_o());
    sabc_comp_model u_comp (.vin_i(vin), .ladder_i(ladder_code_o), .comp_o(comp_i));
    initial begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end
    // free-running loop: interrupt wired back to the start strobe
    always @(posedge mclk_i) if (free_q) wr_n_i <= conv_done_irq_n_o;
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic cmp8(string what, logic [7:0] exp, logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic cmp_rng(string what, int lo, int hi, int got);
        check_count++;
        if (got < lo || got > hi) begin
            n_fail++;
            $display("unexpected %s exp %0d..%0d got %0d", what, lo, hi, got);
        end
    endtask
    // counts settled cycles until the interrupt pin shows lvl; a hang ends the run
    task automatic wait_irq(logic lvl, int lim);
        n = 0;
        while (conv_done_irq_n_o !== lvl) begin
            @(negedge mclk_i);
            n++;
            if (n > lim) begin
                n_fail++;
                end_of_test();
            end
        end
    endtask
    task automatic start(logic [7:0] v);
        @(posedge mclk_i);
        vin    <= v;
        cs_n_i <= 1'b0;
        wr_n_i <= 1'b0;
        repeat (3) @(posedge mclk_i);
        wr_n_i <= 1'b1;
    endtask
    task automatic read_check(logic [7:0] v);
        repeat (10) @(posedge mclk_i);
        rd_n_i <= 1'b0;
        repeat (6) @(negedge mclk_i);
        cmp8("data", v, data_o);
        cmp8("oe", 8'hff, data_oe_o);
        cmp8("irq", 8'h01, {7'h0, conv_done_irq_n_o});
        @(posedge mclk_i);
        cs_n_i <= 1'b1;
        rd_n_i <= 1'b1;
        repeat (6) @(negedge mclk_i);
        cmp8("oe off", 8'h00, data_oe_o);
    endtask
    task automatic t_convert(logic [7:0] v);
        start(v);
        wait_irq(1'b0, 200);
        cmp_rng("conv cycles", 64, 78, n);
        read_check(v);
    endtask
    task automatic t_abort();
        start(8'h33);
        repeat (30) @(posedge mclk_i);
        start(8'hc3);
        wait_irq(1'b0, 200);
        cmp_rng("restart cycles", 64, 78, n);
        read_check(8'hc3);
    endtask
    task automatic t_cont_read();
        @(posedge mclk_i);
        rd_n_i <= 1'b0;
        start(8'h96);
        wait_irq(1'b0, 200);
        wait_irq(1'b1, 40);
        cmp_rng("irq low width", 8, 9, n);
        cmp8("data held", 8'h96, data_o);
        @(posedge mclk_i);
        rd_n_i <= 1'b1;
    endtask
    task automatic t_free_run();
        start(8'h5a);
        free_q <= 1'b1;
        wait_irq(1'b0, 200);
        wait_irq(1'b1, 200);
        // loop register, pin sync and edge detect add about five cycles
        cmp_rng("free pulse", int'(sabc_pkg::FREE_PULSE_CYC),
            int'(sabc_pkg::FREE_PULSE_CYC) + 6, n);
        wait_irq(1'b0, 200);
        cmp_rng("free restart", 64, 84, n);
    endtask
    initial begin
        srst_i      = 1'b1;
        cs_n_i      = 1'b1;
        rd_n_i      = 1'b1;
        wr_n_i      = 1'b1;
        vin         = 8'h00;
        free_q      = 1'b0;
        n_fail      = 0;
        check_count = 0;
        repeat (10) @(posedge mclk_i);
        srst_i <= 1'b0;
        foreach (codes[i]) t_convert(codes[i]);
        t_abort();
        t_cont_read();
        t_free_run();
        end_of_test();
    end
endmodule
